/* File: rtl/fdcr_cfg.svh */
// Register indices, field positions and reset values of the fractional divider configuration bank
`ifndef FDCR_CFG_SVH
`define FDCR_CFG_SVH

// ==================================================================
// Register indices (byte address is four times the index)
`define FDCR_IDX_FIXED_A     6'h20
`define FDCR_IDX_FIXED_B     6'h21
`define FDCR_IDX_NDIV_HIGH   6'h22
`define FDCR_IDX_FIXED_C     6'h23
`define FDCR_IDX_NDIV_LOW    6'h24
`define FDCR_IDX_DLY_CFG     6'h25
`define FDCR_IDX_DEN_HIGH    6'h26
`define FDCR_IDX_DEN_LOW     6'h27
`define FDCR_IDX_SEED_HIGH   6'h28
`define FDCR_IDX_SEED_LOW    6'h29
`define FDCR_IDX_NUM_HIGH    6'h2A
`define FDCR_IDX_NUM_LOW     6'h2B
`define FDCR_IDX_MOD_CTRL    6'h2C
`define FDCR_IDX_STATUS      6'h30
`define FDCR_NUM_WORDS       13

// ==================================================================
// Reset values
`define FDCR_RST_FIXED_A     16'h0393
`define FDCR_RST_FIXED_B     16'h1E21
`define FDCR_RST_NDIV_HIGH   16'h0010
`define FDCR_RST_FIXED_C     16'h0004
`define FDCR_RST_NDIV_LOW    16'h0070
`define FDCR_RST_DLY_CFG     16'h0205
`define FDCR_RST_DEN_HIGH    16'hFFFF
`define FDCR_RST_DEN_LOW     16'hFFFF
`define FDCR_RST_SEED_HIGH   16'h0000
`define FDCR_RST_SEED_LOW    16'h0000
`define FDCR_RST_NUM_HIGH    16'h0000
`define FDCR_RST_NUM_LOW     16'h0000
`define FDCR_RST_MOD_CTRL    16'h22A2

// ==================================================================
// Field positions
`define FDCR_NHI_MSB         2
`define FDCR_DLY_MSB         13
`define FDCR_DLY_LSB         8
`define FDCR_ORDER_MSB       2
`define FDCR_MRST_BIT        5

`endif

/* File: rtl/fdcr_pkg.sv */
// Types shared by the fractional divider configuration bank
package fdcr_pkg;

  // ==================================================================
  // Modulator order codes
  typedef enum logic [2:0] {
    FDCR_ORD_INTEGER = 3'h0,
    FDCR_ORD_FIRST   = 3'h1,
    FDCR_ORD_SECOND  = 3'h2,
    FDCR_ORD_THIRD   = 3'h3
  } fdcr_order_type;

  // ==================================================================
  // Assembled divider configuration
  typedef struct packed {
    logic [18:0] int_div;
    logic [31:0] num;
    logic [31:0] den;
    logic [31:0] seed;
    logic [2:0]  order;
    logic        mod_run;
  } fdcr_frac_cfg_type;

endpackage : fdcr_pkg

/* File: rtl/fdcr_word_reg.sv */
// One 16-bit configuration word with byte-lane writes and a fixed reset value
`timescale 1ns/10ps
`default_nettype none

module fdcr_word_reg #(
  parameter logic [15:0] RESET = 16'h0000
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr_en,
  input  wire logic [1:0]  strb,
  input  wire logic [15:0] wdata,
  output logic      [15:0] q
);

  logic [15:0] q_r;

  assign q = q_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= RESET;
    end else begin
      if (wr_en && strb[0]) q_r[7:0]  <= wdata[7:0];
      if (wr_en && strb[1]) q_r[15:8] <= wdata[15:8];
    end
  end

endmodule : fdcr_word_reg

`default_nettype wire

/* File: rtl/fdcr_frac_engine.sv */
// Cascaded sigma-delta modulator producing the per-cycle feedback divide value
`timescale 1ns/10ps
`default_nettype none

module fdcr_frac_engine #(
  parameter int WIDTH = 32
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire fdcr_pkg::fdcr_frac_cfg_type cfg,
  output logic      [19:0]                divide_value
);

  localparam int STAGES = 3;

  // ==================================================================
  // Elaboration check
  if (WIDTH != 32) begin : g_bad_width
    $error("fdcr_frac_engine: WIDTH must be 32");
  end

  logic [WIDTH-1:0]  acc_r [STAGES];
  logic [STAGES-1:0] cg;
  logic              c2z_r;
  logic              c3z_r;
  logic              c3zz_r;
  logic [19:0]       divide_r;
  wire               den_ok = (cfg.den != '0);

  // ==================================================================
  // Accumulator stages; a zero denominator falls back to integer mode
  for (genvar k = 0; k < STAGES; k++) begin : g_stage
    wire [WIDTH-1:0] in_k   = (k == 0) ? cfg.num[WIDTH-1:0] : acc_r[(k == 0) ? 0 : k - 1];
    wire [WIDTH:0]   sum    = {1'b0, acc_r[k]} + {1'b0, in_k};
    wire             carry  = (sum >= {1'b0, cfg.den[WIDTH-1:0]});
    wire [WIDTH:0]   wrap   = sum - {1'b0, cfg.den[WIDTH-1:0]};
    wire [WIDTH-1:0] nxt    = carry ? wrap[WIDTH-1:0] : sum[WIDTH-1:0];
    wire             active = cfg.mod_run && den_ok && (cfg.order > 3'(k));
    wire [WIDTH-1:0] idle   = (k == 0) ? cfg.seed[WIDTH-1:0] : '0;
    assign cg[k] = active && carry;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) acc_r[k] <= '0;
      else          acc_r[k] <= active ? nxt : idle;
    end
  end

  // ==================================================================
  // Noise-shaping combine: c1 + (1-z)c2 + (1-z)^2 c3
  wire [3:0]  corr = {3'h0, cg[0]} + {3'h0, cg[1]} - {3'h0, c2z_r}
                   + {3'h0, cg[2]} - {2'h0, c3z_r, 1'b0} + {3'h0, c3zz_r};
  wire [19:0] divide_nxt = {1'b0, cfg.int_div} + {{16{corr[3]}}, corr};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c2z_r    <= 1'b0;
      c3z_r    <= 1'b0;
      c3zz_r   <= 1'b0;
      divide_r <= 20'h00000;
    end else begin
      c2z_r    <= cg[1];
      c3z_r    <= cg[2];
      c3zz_r   <= c3z_r;
      divide_r <= divide_nxt;
    end
  end

  assign divide_value = divide_r;

endmodule : fdcr_frac_engine

`default_nettype wire

/* File: rtl/fdcr_top.sv */
// APB register bank holding the feedback divider and fractional modulator configuration
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "fdcr_cfg.svh"

// Functional notes
// - Integer divide is 19 bits from two words
// - Low integer divide word resets to 0x70
// - Denominator is two halves, each resets 0xFFFF
// - Numerator is two halves, both reset zero
// - Seed loads modulator initial state, resets zero
// - Order field selects mode; reset bit holds modulator
module fdcr_top #(
  parameter int ADDR_WIDTH = 8
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ADDR_WIDTH-1:0]       paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  output fdcr_pkg::fdcr_frac_cfg_type      frac_cfg,
  output logic      [5:0]                  detector_delay_select,
  output logic      [19:0]                 divide_value
);

  // ==================================================================
  // Elaboration check
  if (ADDR_WIDTH < 8) begin : g_bad_addr
    $error("fdcr_top: ADDR_WIDTH must be at least 8 to reach the status word");
  end

  // ==================================================================
  // Address decode
  logic [15:0] words [`FDCR_NUM_WORDS];
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic [19:0] engine_divide;
  logic [19:0] divide_r;

  // True when an index falls in the writable configuration window
  function automatic logic in_bank(input logic [5:0] idx);
    in_bank = (idx >= `FDCR_IDX_FIXED_A) && (idx <= `FDCR_IDX_MOD_CTRL);
  endfunction : in_bank

  // Word number within the bank for an index inside it
  function automatic logic [3:0] bank_slot(input logic [5:0] idx);
    logic [5:0] off;
    off       = idx - `FDCR_IDX_FIXED_A;
    bank_slot = off[3:0];
  endfunction : bank_slot

  // Reset value of each slot, used at elaboration for the word registers
  function automatic logic [15:0] slot_reset(input int slot);
    logic [15:0] v;
    v = 16'h0000;
    case (slot)
      0:       v = `FDCR_RST_FIXED_A;
      1:       v = `FDCR_RST_FIXED_B;
      2:       v = `FDCR_RST_NDIV_HIGH;
      3:       v = `FDCR_RST_FIXED_C;
      4:       v = `FDCR_RST_NDIV_LOW;
      5:       v = `FDCR_RST_DLY_CFG;
      6:       v = `FDCR_RST_DEN_HIGH;
      7:       v = `FDCR_RST_DEN_LOW;
      8:       v = `FDCR_RST_SEED_HIGH;
      9:       v = `FDCR_RST_SEED_LOW;
      10:      v = `FDCR_RST_NUM_HIGH;
      11:      v = `FDCR_RST_NUM_LOW;
      12:      v = `FDCR_RST_MOD_CTRL;
      default: v = 16'h0000;
    endcase
    slot_reset = v;
  endfunction : slot_reset

  wire [5:0] idx        = paddr[7:2];
  wire       high_zero  = (ADDR_WIDTH == 8) ? 1'b1 : (paddr >> 8) == '0;
  wire       aligned    = (paddr[1:0] == 2'h0) && high_zero;
  wire       bank_hit   = aligned && in_bank(idx);
  wire       status_hit = aligned && (idx == `FDCR_IDX_STATUS);
  wire       addr_err   = !(bank_hit || status_hit);
  wire [3:0] slot       = bank_slot(idx);
  wire       setup      = psel && !penable;
  wire       access     = psel && penable;
  // Unmapped writes are refused; status writes are ignored without error
  wire       wr_go      = access && pwrite && bank_hit;

  // ==================================================================
  // Configuration words; every bit is stored as written, reserved ones too
  // Software keeps the fixed patterns; the bank does not police them
  for (genvar i = 0; i < `FDCR_NUM_WORDS; i++) begin : g_word
    fdcr_word_reg #(
      .RESET (slot_reset(i))
    ) u_word (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (wr_go && (slot == 4'(i))),
      .strb    (pstrb[1:0]),
      .wdata   (pwdata[15:0]),
      .q       (words[i])
    );
  end

  // ==================================================================
  // Field assembly
  wire [15:0] w_nhi  = words[2];
  wire [15:0] w_nlo  = words[4];
  wire [15:0] w_dly  = words[5];
  wire [15:0] w_mctl = words[12];

  fdcr_pkg::fdcr_frac_cfg_type cfg_r;
  fdcr_pkg::fdcr_frac_cfg_type cfg_nxt;

  always_comb begin
    cfg_nxt         = '0;
    cfg_nxt.int_div = {w_nhi[`FDCR_NHI_MSB:0], w_nlo};
    cfg_nxt.den     = {words[6], words[7]};
    cfg_nxt.num     = {words[10], words[11]};
    cfg_nxt.seed    = {words[8], words[9]};
    cfg_nxt.order   = w_mctl[`FDCR_ORDER_MSB:0];
    cfg_nxt.mod_run = w_mctl[`FDCR_MRST_BIT];
  end

  // Registered, so each written half reaches the engine one cycle after its word register updates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_r <= '0;
    else          cfg_r <= cfg_nxt;
  end

  fdcr_frac_engine #(
    .WIDTH (32)
  ) u_engine (
    .pclk         (pclk),
    .presetn      (presetn),
    .cfg          (cfg_r),
    .divide_value (engine_divide)
  );

  // ==================================================================
  // Read path; data is captured in the setup cycle, so no wait state
  wire [15:0] bank_word = bank_hit ? words[slot] : 16'h0000;
  wire [31:0] rd_data   = status_hit ? {12'h000, divide_r} : {16'h0000, bank_word};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
      divide_r  <= 20'h00000;
    end else begin
      divide_r <= engine_divide;
      if (setup) begin
        prdata_r  <= (pwrite || addr_err) ? 32'h00000000 : rd_data;
        pslverr_r <= addr_err;
      end
    end
  end

  // ==================================================================
  // Outputs
  assign pready                = 1'b1;
  assign prdata                = prdata_r;
  assign pslverr               = pslverr_r && access;
  assign frac_cfg              = cfg_r;
  assign detector_delay_select = w_dly[`FDCR_DLY_MSB:`FDCR_DLY_LSB];
  assign divide_value          = divide_r;

endmodule : fdcr_top

`default_nettype wire

/* File: testbench/fdcr_top_properties.sv */
// Port checks for the divider configuration bank
`timescale 1ns/10ps
`default_nettype none
module fdcr_top_chk #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [ADDR_WIDTH-1:0]       paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [3:0]                  pstrb,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire fdcr_pkg::fdcr_frac_cfg_type frac_cfg,
  input wire logic [5:0]                  detector_delay_select,
  input wire logic [19:0]                 divide_value
);
  // ==================================================================
  // Helpers: only full-lane writes are tracked, partial lanes go to the bench
  wire logic        wr = psel & penable & pwrite & pready & (pstrb[1:0] == 2'b11);
  wire logic [7:0]  a  = paddr[7:0];
  wire logic [15:0] wd = pwdata[15:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==================================================================
  // Checks
  a_ndiv_low: assert property (wr && a == 8'h90 |-> ##2 frac_cfg.int_div[15:0] == $past(wd, 2))
    else $error("int divide low word not applied");
  a_ndiv_high: assert property (wr && a == 8'h88 |-> ##2 frac_cfg.int_div[18:16] == $past(wd[2:0], 2))
    else $error("int divide high bits not applied");
  a_den_high: assert property (wr && a == 8'h98 |-> ##2 frac_cfg.den[31:16] == $past(wd, 2))
    else $error("denominator high not applied");
  a_num_high: assert property (wr && a == 8'hA8 |-> ##2 frac_cfg.num[31:16] == $past(wd, 2))
    else $error("numerator high not applied");
  a_seed_high: assert property (wr && a == 8'hA0 |-> ##2 frac_cfg.seed[31:16] == $past(wd, 2))
    else $error("seed high not applied");
  a_order_ctrl: assert property (wr && a == 8'hB0 |-> ##2 frac_cfg.order == $past(wd[2:0], 2)
    && frac_cfg.mod_run == $past(wd[5], 2))
    else $error("order or run bit not applied");
  a_reset_cfg: assert property ($rose(presetn) |=> frac_cfg.int_div == 19'h00070
    && frac_cfg.den == 32'hFFFFFFFF)
    else $error("reset configuration wrong");
  // Two pipeline stages lie between the config and the output, and the delayed carries need three idle cycles
  a_int_mode: assert property (frac_cfg.order == 3'h0 [*3] |=> ##1 divide_value == {1'b0, $past(frac_cfg.int_div, 2)})
    else $error("integer mode divide wrong");
endmodule : fdcr_top_chk
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the divider configuration bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]                  paddr;
  logic [31:0]                 pwdata, prdata, rd;
  logic [3:0]                  pstrb;
  logic [5:0]                  dly;
  logic [19:0]                 dv;
  fdcr_pkg::fdcr_frac_cfg_type cfg;
  int                          err_total, checks_done, sum;
  logic [15:0]                 mdl [13];
  localparam logic [15:0] RV [13] = '{16'h0393, 16'h1E21, 16'h0010, 16'h0004, 16'h0070, 16'h0205,
    16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h22A2};
  localparam logic [15:0] MODE [5] = '{16'h0000, 16'h0021, 16'h0022, 16'h0023, 16'h0002};
  fdcr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frac_cfg(cfg), .detector_delay_select(dly), .divide_value(dv));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ==================================================================
  // Tasks
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    $display("Counts: %0d checks, %0d mismatches", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  // Entered just after a rising edge, or a falling one after the averaging loop; leaves one idle cycle so psel is never driven twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input int i, input logic [15:0] d, input logic [3:0] s);
    apb(1'b1, 8'(128 + 4 * i), {16'h0000, d}, s);
    if (s[0]) mdl[i][7:0] = d[7:0];
    if (s[1]) mdl[i][15:8] = d[15:8];
  endtask : wr
  task automatic rd_all();
    for (int i = 0; i < 13; i++) begin
      apb(1'b0, 8'(128 + 4 * i), 32'h0, 4'h0);
      chk("reg", rd, {16'h0000, mdl[i]});
    end
  endtask : rd_all
  task automatic cfg_chk();
    @(negedge pclk);
    chk("frac_cfg", cfg, {mdl[2][2:0], mdl[4], mdl[10], mdl[11], mdl[6], mdl[7], mdl[8], mdl[9],
      mdl[12][2:0], mdl[12][5]});
    chk("delay_sel", dly, mdl[5][13:8]);
    @(posedge pclk);
  endtask : cfg_chk
  // ==================================================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    err_total = 0;
    checks_done = 0;
    mdl = RV;
    void'($urandom(32'hBC2C));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cfg_chk();
    rd_all();
    $display("test reset done");
    repeat (3) begin
      for (int i = 0; i < 13; i++) wr(i, 16'($urandom), 4'($urandom));
      cfg_chk();
      rd_all();
    end
    $display("test random done");
    apb(1'b0, 8'h40, 32'h0, 4'h0);
    chk("unmapped_err", {er, rd}, {1'b1, 32'h0});
    apb(1'b1, 8'h91, 32'hFFFF, 4'h3);
    chk("misaligned_err", er, 1'b1);
    apb(1'b1, 8'hC0, 32'hFFFF, 4'h3);
    chk("status_err", er, 1'b0);
    $display("test refusal done");
    wr(12, 16'h0000, 4'h3);
    wr(0, 16'h0393, 4'h3);
    wr(1, 16'h1E21, 4'h3);
    wr(3, 16'h0004, 4'h3);
    wr(5, 16'h8A04, 4'h3);
    wr(2, 16'h0000, 4'h3);
    wr(4, 16'd100, 4'h3);
    wr(6, 16'h0000, 4'h3);
    wr(7, 16'h0008, 4'h3);
    wr(10, 16'h0000, 4'h3);
    wr(11, 16'h0003, 4'h3);
    wr(8, 16'h0000, 4'h3);
    wr(9, 16'h0000, 4'h3);
    cfg_chk();
    rd_all();
    // Stages are parked while configuring, so the accumulators never see num above den
    for (int m = 0; m < 5; m++) begin
      wr(12, MODE[m], 4'h3);
      repeat (10) @(posedge pclk);
      sum = 0;
      repeat (800) begin
        @(negedge pclk);
        sum += int'(dv);
      end
      sum -= 80000 + ((MODE[m][5] && MODE[m][2:0] != 3'h0) ? 300 : 0);
      chk("avg_divide", (sum >= -4 && sum <= 4), 1'b1);
      if (!MODE[m][5] || MODE[m][2:0] == 3'h0) begin
        apb(1'b0, 8'hC0, 32'h00000000, 4'h0);
        chk("status_divide", {er, rd}, {1'b0, 32'h00000064});
      end
    end
    $display("test modulator done");
    final_report();
  end
endmodule : tb
bind fdcr_top fdcr_top_chk #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .frac_cfg(frac_cfg), .detector_delay_select(detector_delay_select),
  .divide_value(divide_value));
`default_nettype wire
